// file: rtl/ccrc_cfg.svh
/*
 * Register offsets, reset values, field positions and frame layout for
 * the clock, sync and range configuration bank.
 * Assumes inclusion by bare name from the package; the bank module only uses its macros.
 */
`ifndef CCRC_CFG_SVH
`define CCRC_CFG_SVH

// Byte addresses on the serial configuration port
`define CCRC_ADDR_CLK_CTRL_A    15'h002a
`define CCRC_ADDR_CLK_CTRL_B    15'h002b
`define CCRC_ADDR_EDGE_POS_0    15'h002c
`define CCRC_ADDR_EDGE_POS_1    15'h002d
`define CCRC_ADDR_EDGE_POS_2    15'h002e
`define CCRC_ADDR_FS_CODE_0     15'h0030
`define CCRC_ADDR_FS_CODE_1     15'h0031
`define CCRC_ADDR_PWR_MODE_1    15'h0037

// Reset values
`define CCRC_RST_CLK_CTRL_A     8'h00
`define CCRC_RST_CLK_CTRL_B     8'h10
`define CCRC_RST_FS_CODE        16'ha000
`define CCRC_RST_PWR_MODE_1     8'h4b

// Field positions
`define CCRC_BIT_SAMPLE_PECL    2
`define CCRC_BIT_SYNC_PECL      1
`define CCRC_BIT_SYNC_INVERT    0
`define CCRC_BIT_ACLK_QUIET     2
`define CCRC_BIT_CLK_QUIET      0

// Power mode codes
`define CCRC_PWR_LOW            8'h46
`define CCRC_PWR_HIGH_PERF      8'h4b

// Serial frame: one direction bit, fifteen address bits, then data bytes
`define CCRC_HDR_LAST           4'hf
`define CCRC_BYTE_LAST          4'h7

`endif

// file: rtl/ccrc_pkg.sv
/*
 * Types shared by the clock, sync and range configuration bank.
 * Assumes the constants header is on the include path.
 */
package ccrc_pkg;

    `include "ccrc_cfg.svh"

    typedef struct packed {
        logic        sample_clock_pecl_select;
        logic        sync_input_pecl_select;
        logic        sync_polarity_invert;
        logic        analog_clock_supply_quiet_en;
        logic        clock_supply_quiet_en;
        logic [15:0] full_scale_code;
        logic [7:0]  power_mode_code;
        logic        power_mode_low;
    } ccrc_ctrl_t;

    typedef struct packed {
        logic sclk;
        logic sen_n;
        logic sdi;
    } ccrc_spi_in_t;

endpackage

// file: rtl/ccrc_regs.sv
/*
 * Clock, sync and range configuration registers behind a serial
 * configuration port, oversampled on mclk.
 * Assumes sclk runs at most mclk/8 and that sync_edge_position comes
 * from core logic on mclk; serial pins and the sync pin are asynchronous.
 */
`timescale 1ns/1ps

module ccrc_regs
    import ccrc_pkg::*;
(
    input  wire logic         mclk,
    input  wire logic         rst_n,
    input  wire ccrc_spi_in_t spi_in,
    output logic              sdo,
    output logic              sdo_oe,
    input  wire logic [23:0]  sync_edge_position,
    input  wire logic         sync_in,
    output logic              sync_aligned,
    output ccrc_ctrl_t        ctrl
);

    logic [2:0]  pin_s1_r;
    logic [2:0]  pin_s2_r;
    logic        sclk_d_r;
    logic        sync_s1_r;
    logic        sync_s2_r;
    logic [14:0] shift_in_r;
    logic [3:0]  bit_cnt_r;
    logic        in_hdr_r;
    logic        rd_dir_r;
    logic [14:0] addr_r;
    logic        load_tx_r;
    logic [7:0]  tx_r;
    logic [7:0]  clk_ctrl_a_r;
    logic [7:0]  clk_ctrl_b_r;
    logic [15:0] fs_code_r;
    logic [7:0]  pwr_mode_r;
    logic        sclk_s;
    logic        sen_n_s;
    logic        sdi_s;
    logic        rise;
    logic        fall;
    logic        byte_done;
    logic        wr_fire;
    logic [7:0]  wr_data;
    logic [7:0]  rd_byte;

    // Two flops on every asynchronous pin
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_r <= 3'h7;
            pin_s2_r <= 3'h7;
            sclk_d_r <= 1'b1;
        end else begin
            pin_s1_r <= {spi_in.sclk, spi_in.sen_n, spi_in.sdi};
            pin_s2_r <= pin_s1_r;
            sclk_d_r <= pin_s2_r[2];
        end
    end

    assign sclk_s    = pin_s2_r[2];
    assign sen_n_s   = pin_s2_r[1];
    assign sdi_s     = pin_s2_r[0];
    assign rise      = sclk_s & ~sclk_d_r & ~sen_n_s;
    assign fall      = ~sclk_s & sclk_d_r & ~sen_n_s;
    assign byte_done = rise & ~in_hdr_r & (bit_cnt_r == `CCRC_BYTE_LAST);
    assign wr_fire   = byte_done & ~rd_dir_r;
    assign wr_data   = {shift_in_r[6:0], sdi_s};

    // Frame sequencing: header, then bytes with ascending address
    // Partial byte at frame end is dropped
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            shift_in_r <= 15'h0000;
            bit_cnt_r  <= 4'h0;
            in_hdr_r   <= 1'b1;
            rd_dir_r   <= 1'b0;
            addr_r     <= 15'h0000;
            load_tx_r  <= 1'b0;
        end else begin
            load_tx_r <= 1'b0;
            if (sen_n_s) begin
                bit_cnt_r <= 4'h0;
                in_hdr_r  <= 1'b1;
            end else if (rise) begin
                shift_in_r <= {shift_in_r[13:0], sdi_s};
                bit_cnt_r  <= bit_cnt_r + 4'h1;
                if (in_hdr_r && bit_cnt_r == `CCRC_HDR_LAST) begin
                    rd_dir_r  <= shift_in_r[14];
                    addr_r    <= {shift_in_r[13:0], sdi_s};
                    in_hdr_r  <= 1'b0;
                    bit_cnt_r <= 4'h0;
                    load_tx_r <= 1'b1;
                end else if (byte_done) begin
                    addr_r    <= addr_r + 15'h0001;
                    bit_cnt_r <= 4'h0;
                    load_tx_r <= 1'b1;
                end
            end
        end
    end

    // Read mux; unmapped addresses read zero
    // Position status has no write path
    always_comb begin
        unique case (addr_r)
            `CCRC_ADDR_CLK_CTRL_A: rd_byte = clk_ctrl_a_r;
            `CCRC_ADDR_CLK_CTRL_B: rd_byte = clk_ctrl_b_r;
            `CCRC_ADDR_EDGE_POS_0: rd_byte = sync_edge_position[7:0];
            `CCRC_ADDR_EDGE_POS_1: rd_byte = sync_edge_position[15:8];
            `CCRC_ADDR_EDGE_POS_2: rd_byte = sync_edge_position[23:16];
            `CCRC_ADDR_FS_CODE_0:  rd_byte = fs_code_r[7:0];
            `CCRC_ADDR_FS_CODE_1:  rd_byte = fs_code_r[15:8];
            `CCRC_ADDR_PWR_MODE_1: rd_byte = pwr_mode_r;
            default:               rd_byte = 8'h00;
        endcase
    end

    // Serial output shifts on falling sclk, driven only in a read frame
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tx_r   <= 8'h00;
            sdo    <= 1'b0;
            sdo_oe <= 1'b0;
        end else begin
            sdo_oe <= ~sen_n_s & ~in_hdr_r & rd_dir_r;
            // Load one cycle after the address update settles the mux
            if (load_tx_r) begin
                tx_r <= rd_byte;
            end else if (fall && !in_hdr_r && rd_dir_r) begin
                sdo  <= tx_r[7];
                tx_r <= {tx_r[6:0], 1'b0};
            end
        end
    end

    // Whole bytes stored, reserved bits included
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            clk_ctrl_a_r <= `CCRC_RST_CLK_CTRL_A;
        end else if (wr_fire && addr_r == `CCRC_ADDR_CLK_CTRL_A) begin
            clk_ctrl_a_r <= wr_data;
        end
    end

    // Supply noise suppression enables
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            clk_ctrl_b_r <= `CCRC_RST_CLK_CTRL_B;
        end else if (wr_fire && addr_r == `CCRC_ADDR_CLK_CTRL_B) begin
            clk_ctrl_b_r <= wr_data;
        end
    end

    // Range code in two byte halves
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            fs_code_r <= `CCRC_RST_FS_CODE;
        end else if (wr_fire && addr_r == `CCRC_ADDR_FS_CODE_0) begin
            fs_code_r[7:0] <= wr_data;
        end else if (wr_fire && addr_r == `CCRC_ADDR_FS_CODE_1) begin
            fs_code_r[15:8] <= wr_data;
        end
    end

    // Mode code; reserved codes kept as written
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pwr_mode_r <= `CCRC_RST_PWR_MODE_1;
        end else if (wr_fire && addr_r == `CCRC_ADDR_PWR_MODE_1) begin
            pwr_mode_r <= wr_data;
        end
    end

    // Registered control outputs toward the core
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= '0;
        end else begin
            ctrl.sample_clock_pecl_select     <= clk_ctrl_a_r[`CCRC_BIT_SAMPLE_PECL];
            ctrl.sync_input_pecl_select       <= clk_ctrl_a_r[`CCRC_BIT_SYNC_PECL];
            ctrl.sync_polarity_invert         <= clk_ctrl_a_r[`CCRC_BIT_SYNC_INVERT];
            ctrl.analog_clock_supply_quiet_en <= clk_ctrl_b_r[`CCRC_BIT_ACLK_QUIET];
            ctrl.clock_supply_quiet_en        <= clk_ctrl_b_r[`CCRC_BIT_CLK_QUIET];
            ctrl.full_scale_code              <= fs_code_r;
            ctrl.power_mode_code              <= pwr_mode_r;
            ctrl.power_mode_low               <= (pwr_mode_r == `CCRC_PWR_LOW);
        end
    end

    // Sync pin synchronised, then optionally inverted
    // Polarity from the stored bit, in step with ctrl
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sync_s1_r    <= 1'b0;
            sync_s2_r    <= 1'b0;
            sync_aligned <= 1'b0;
        end else begin
            sync_s1_r    <= sync_in;
            sync_s2_r    <= sync_s1_r;
            sync_aligned <= sync_s2_r ^ clk_ctrl_a_r[`CCRC_BIT_SYNC_INVERT];
        end
    end

endmodule

// file: tb/ccrc_regs_bench.sv
/* Self-checking bench for the clock, sync and range bank.
 * Assumes the bank's serial frame format and the bound checker. */
`timescale 1ns/1ps
module ccrc_regs_bench;
    import ccrc_pkg::*;
    logic         mclk, rst_n, sdo, sdo_oe, sync_in, sync_aligned;
    logic [23:0]  pos;
    logic [7:0]   rd;
    ccrc_spi_in_t spi_in;
    ccrc_ctrl_t   ctrl;
    int           error_cnt, checks;
    ccrc_regs dut (.mclk(mclk), .rst_n(rst_n), .spi_in(spi_in), .sdo(sdo), .sdo_oe(sdo_oe),
        .sync_edge_position(pos), .sync_in(sync_in), .sync_aligned(sync_aligned), .ctrl(ctrl));
    always #2 mclk = ~mclk;
    task automatic complete_run;
        if (error_cnt == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic bit_io(input logic b, output logic r);
        spi_in.sclk = 1'b0;
        spi_in.sdi = b;
        repeat (10) @(negedge mclk);
        spi_in.sclk = 1'b1;
        r = sdo;
        repeat (10) @(negedge mclk);
    endtask
    // One frame of one byte; reads compare against d
    task automatic xfer(input logic rw, input logic [14:0] a, input logic [7:0] d);
        logic [23:0] f;
        f = {rw, a, rw ? 8'h00 : d};
        spi_in.sen_n = 1'b0;
        repeat (4) @(negedge mclk);
        for (int i = 23; i >= 0; i--) bit_io(f[i], rd[i % 8]);
        repeat (4) @(negedge mclk);
        spi_in.sen_n = 1'b1;
        repeat (12) @(negedge mclk);
        if (rw) chk(rd, d);
    endtask
    // Two bytes in one frame at ascending addresses; d[15:8] goes to address a
    task automatic xfer2(input logic rw, input logic [14:0] a, input logic [15:0] d);
        logic [31:0] f;
        logic [15:0] r2;
        f = {rw, a, rw ? 16'h0000 : d};
        spi_in.sen_n = 1'b0;
        repeat (4) @(negedge mclk);
        for (int i = 31; i >= 0; i--) bit_io(f[i], r2[i % 16]);
        repeat (4) @(negedge mclk);
        spi_in.sen_n = 1'b1;
        repeat (12) @(negedge mclk);
        if (rw) chk(r2, d);
    endtask
    task automatic do_reset;
        rst_n = 1'b0;
        repeat (20) @(negedge mclk);
        rst_n = 1'b1;
        repeat (8) @(negedge mclk);
    endtask
    initial begin
        mclk = 1'b0;
        spi_in = 3'b110;
        sync_in = 1'b0;
        pos = 24'ha5c3e1;
        error_cnt = 0;
        checks = 0;
        do_reset();
        chk(ctrl.full_scale_code, 16'ha000);
        xfer(1'b1, 15'h002a, 8'h00);
        xfer(1'b1, 15'h002b, 8'h10);
        xfer(1'b1, 15'h0031, 8'ha0);
        xfer(1'b1, 15'h0037, 8'h4b);
        // Each select alone, upper bits held at their reset value
        for (int k = 0; k < 3; k++) begin
            xfer(1'b0, 15'h002a, 8'h01 << k);
            xfer(1'b1, 15'h002a, 8'h01 << k);
            chk(ctrl[29:27], 3'h1 << k);
        end
        xfer(1'b0, 15'h002a, 8'h01);
        repeat (6) @(negedge mclk);
        chk(sync_aligned, 1'b1);
        sync_in = 1'b1;
        repeat (6) @(negedge mclk);
        chk(sync_aligned, 1'b0);
        sync_in = 1'b0;
        xfer(1'b0, 15'h002b, 8'h15);
        xfer(1'b1, 15'h002b, 8'h15);
        chk(ctrl[26:25], 2'h3);
        for (int k = 0; k < 3; k++) xfer(1'b1, 15'h002c + 15'(k), pos[8 * k +: 8]);
        xfer(1'b0, 15'h002e, 8'hff);
        xfer(1'b1, 15'h002e, 8'ha5);
        pos = 24'h3c5a96;
        xfer(1'b1, 15'h002c, 8'h96);
        xfer2(1'b1, 15'h002d, 16'h5a3c);
        xfer(1'b0, 15'h0031, 8'h20);
        xfer(1'b0, 15'h0030, 8'hff);
        chk(ctrl.full_scale_code, 16'h20ff);
        xfer2(1'b0, 15'h0030, 16'h00ff);
        chk(ctrl.full_scale_code, 16'hff00);
        xfer2(1'b1, 15'h0030, 16'h00ff);
        xfer(1'b0, 15'h0037, 8'h46);
        chk(ctrl.power_mode_low, 1'b1);
        xfer(1'b0, 15'h0037, 8'h47);
        xfer(1'b1, 15'h0037, 8'h47);
        chk(ctrl.power_mode_low, 1'b0);
        xfer(1'b0, 15'h0037, 8'h46);
        chk(ctrl.power_mode_code, 8'h46);
        xfer(1'b1, 15'h002f, 8'h00);
        do_reset();
        chk(ctrl.full_scale_code, 16'ha000);
        xfer(1'b1, 15'h0037, 8'h4b);
        complete_run();
    end
endmodule

// file: tb/ccrc_regs_properties.sv
/* Concurrent checks on the clock, sync and range bank ports.
 * Assumes one mclk domain with asynchronous active-low reset; bound to ccrc_regs. */
`timescale 1ns/1ps
module ccrc_regs_props
    import ccrc_pkg::*;
(
    input wire logic         mclk,
    input wire logic         rst_n,
    input wire ccrc_spi_in_t spi_in,
    input wire logic         sdo,
    input wire logic         sdo_oe,
    input wire logic         sync_in,
    input wire logic         sync_aligned,
    input wire ccrc_ctrl_t   ctrl
);
    logic [1:0] age_r;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) age_r <= 2'h0;
        else if (age_r != 2'h3) age_r <= age_r + 2'h1;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    property p_rst; age_r == 2'h2 |-> ctrl == {5'h00, 16'ha000, 8'h4b, 1'b0}; endproperty
    a_rst: assert property (p_rst) else $error("ctrl not at reset values");
    property p_low; ctrl.power_mode_low == (ctrl.power_mode_code == 8'h46); endproperty
    a_low: assert property (p_low) else $error("low power flag wrong");
    property p_sync; ($stable(sync_in) && $stable(ctrl.sync_polarity_invert))[*4]
        |-> sync_aligned == (sync_in ^ ctrl.sync_polarity_invert); endproperty
    a_sync: assert property (p_sync) else $error("sync polarity wrong");
    property p_quiet; spi_in.sen_n[*8] |-> $stable(ctrl); endproperty
    a_quiet: assert property (p_quiet) else $error("ctrl moved while idle");
    property p_idle; spi_in.sen_n[*6] |-> !sdo_oe; endproperty
    a_idle: assert property (p_idle) else $error("sdo driven while idle");
    property p_hold; sdo_oe && !spi_in.sen_n |=> sdo_oe; endproperty
    a_hold: assert property (p_hold) else $error("sdo released in frame");
    property p_rise; $rose(sdo_oe) |-> !spi_in.sen_n; endproperty
    a_rise: assert property (p_rise) else $error("sdo driven outside frame");
    property p_sdo; (spi_in.sclk && !spi_in.sen_n)[*8] |-> $stable(sdo); endproperty
    a_sdo: assert property (p_sdo) else $error("sdo moved while sclk high");
endmodule
bind ccrc_regs ccrc_regs_props u_props (.mclk(mclk), .rst_n(rst_n), .spi_in(spi_in), .sdo(sdo),
    .sdo_oe(sdo_oe), .sync_in(sync_in), .sync_aligned(sync_aligned), .ctrl(ctrl));
